/* File: hw/limit_judgment_mode_menu_regs.vh */
// register offsets, field positions, reset values and codes of the limit judgment_mode_menu and sorter
`ifndef LIMIT_JUDGMENT_MODE_MENU_REGS_VH
`define LIMIT_JUDGMENT_MODE_MENU_REGS_VH

`define OFS_CTRL 8'h00
`define OFS_KEY 8'h04
`define OFS_JSEL 8'h08
`define OFS_COND 8'h0C
`define OFS_MENU 8'h10
`define OFS_STATUS 8'h14
`define OFS_DISP_P 8'h18
`define OFS_DISP_S 8'h1C
`define OFS_REF_P 8'h20
`define OFS_REF_S 8'h24
`define OFS_SEC_HI 8'h28
`define OFS_SEC_LO 8'h2C
`define OFS_LIM_HI 8'h40
`define OFS_LIM_LO 8'h80

`define NUM_SLOTS 14
`define NUM_BINS 13

`define CTRL_MODE_LSB 0
`define CTRL_TONE_LSB 2
`define KEY_TRIG 0
`define KEY_SHOT 1
`define KEY_CONFIRM 2
`define COND_AUTO_RANGE 0
`define LIM_OFF_BIT 24
`define MENU_DASH_BIT 8

`define MODE_PLAIN 2'h0
`define MODE_COMPARE 2'h1
`define MODE_SORT 2'h2

`define JMODE_COUNT 2'h0
`define JMODE_DEV_COUNT 2'h1
`define JMODE_DEV_PERCENT 2'h2

`define JUDGMENT_MODE_MENU_NONE 2'h0
`define JUDGMENT_MODE_MENU_BELOW 2'h1
`define JUDGMENT_MODE_MENU_PASS 2'h2
`define JUDGMENT_MODE_MENU_ABOVE 2'h3

`define TONE_PASS_BIT 0
`define TONE_FAIL_BIT 1

`define RST_LIMIT 25'h1000000
`define RST_REF_P 24'h0186A0
`define RST_REF_S 24'h000000
`define RST_COND 16'h0001
`define PERCENT_SCALE 16'h2710

`define MENU_TONE_ITEM 4'h5
`define MENU_CMP_ALLOWED 16'h00FF

`endif

/* File: hw/limit_judgment_mode_menu_and_sorter.v */
// limit judgment and bin sorting core with apb register access
// Function
// - both limits off: no judgment for parameter
// - step 1: error/overflow above, underflow below
// - step 2: below lower limit gives below
// - step 3: above upper limit gives above
// - step 4: otherwise pass
// - per-parameter flags plus combined pass output
// - pass and fail tones selected by config
// - compare mode blocks condition changes except trigger
// - trigger key toggles internal/external source
// - single shot only when external, one measurement
// - compare mode menu subset, others show dash
// - sort: 13 primary pairs, one secondary pair
// - sort category driven on rear port
// - count, deviation count, deviation percent modes
// - count mode displays raw value
// - deviation count displays value minus reference
// - percent: primary scaled percent, secondary difference
// - sort mode survives power cycle
// - disabled bins are not judged
// - sort mode forces range hold
// - shared judgment mode, changed only in plain
// - confirm commits mode, then tone menu item
// - reversed limits accepted without check
//
// Decided for this implementation: the register addresses and the APB register port.
`timescale 1ns/10ps
`default_nettype none
`include "limit_judgment_mode_menu_regs.vh"

module limit_judgment_mode_menu_and_sorter (
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [7:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output reg pready,
	output reg pslverr,
	input wire meas_valid,
	input wire [23:0] meas_primary,
	input wire [23:0] meas_secondary,
	input wire meas_error,
	input wire p_overflow,
	input wire p_underflow,
	input wire s_overflow,
	input wire s_underflow,
	input wire saved_sort_mode,
	output reg saved_sort_mode_out,
	output reg p_below_flag,
	output reg p_pass,
	output reg p_above_flag,
	output reg s_below_flag,
	output reg s_pass,
	output reg s_above_flag,
	output reg and_pass,
	output reg fail_flag,
	output reg [13:0] rear_parallel_port,
	output reg [3:0] sort_category,
	output reg result_valid,
	output reg tone_pass,
	output reg tone_fail,
	output reg trigger_source_select,
	output reg meas_start,
	output reg auto_range
);

	// registers
	reg [1:0] mode_ff;
	reg [1:0] tone_ff;
	reg [1:0] jmode_ff;
	reg [1:0] jsel_ff;
	reg [15:0] cond_ff;
	reg [3:0] menu_ff;
	reg menu_dash_ff;
	reg [23:0] ref_p_ff;
	reg [23:0] ref_s_ff;
	reg [24:0] sec_hi_ff;
	reg [24:0] sec_lo_ff;
	reg [24:0] lim_hi_ff [0:`NUM_SLOTS-1];
	reg [24:0] lim_lo_ff [0:`NUM_SLOTS-1];
	reg [23:0] disp_p_ff;
	reg [23:0] disp_s_ff;
	reg strap_done_ff;

	wire setup = psel & ~penable;
	wire wr_en = psel & penable & pready & pwrite;
	wire is_lim_hi = (paddr >= `OFS_LIM_HI) && (paddr < `OFS_LIM_HI + 8'h38);
	wire is_lim_lo = (paddr >= `OFS_LIM_LO) && (paddr < `OFS_LIM_LO + 8'h38);
	wire [7:0] lim_ofs_hi = paddr - `OFS_LIM_HI;
	wire [7:0] lim_ofs_lo = paddr - `OFS_LIM_LO;
	wire [3:0] hi_idx = lim_ofs_hi[5:2];
	wire [3:0] lo_idx = lim_ofs_lo[5:2];

	function [1:0] judgment_mode_menu;
		input [23:0] v;
		input [24:0] hi;
		input [24:0] lo;
		input err;
		input unf;
		begin
			if (hi[`LIM_OFF_BIT] && lo[`LIM_OFF_BIT])
				judgment_mode_menu = `JUDGMENT_MODE_MENU_NONE;
			else if (err)
				judgment_mode_menu = `JUDGMENT_MODE_MENU_ABOVE;
			else if (unf)
				judgment_mode_menu = `JUDGMENT_MODE_MENU_BELOW;
			// no ordering check of hi against lo: reversed pairs judgment_mode_menu as they fall
			else if (!lo[`LIM_OFF_BIT] && ($signed(v) < $signed(lo[23:0])))
				judgment_mode_menu = `JUDGMENT_MODE_MENU_BELOW;
			else if (!hi[`LIM_OFF_BIT] && ($signed(v) > $signed(hi[23:0])))
				judgment_mode_menu = `JUDGMENT_MODE_MENU_ABOVE;
			else
				judgment_mode_menu = `JUDGMENT_MODE_MENU_PASS;
		end
	endfunction

	// value transform for the active judgment mode
	wire [24:0] diff_p = {meas_primary[23], meas_primary} - {ref_p_ff[23], ref_p_ff};
	wire [24:0] diff_s = {meas_secondary[23], meas_secondary} - {ref_s_ff[23], ref_s_ff};
	wire [23:0] ref_p_abs = ref_p_ff[23] ? (24'h000000 - ref_p_ff) : ref_p_ff;
	wire [40:0] scaled = $signed(diff_p) * $signed({1'b0, `PERCENT_SCALE});
	// percent in hundredths to match the 0.01 % limit resolution; a zero reference
	// is still accepted by the OFS_REF_P write in every mode, and the guard then gives a percent of 0
	wire [40:0] pct_full = (ref_p_abs == 24'h000000) ? 41'sh00000000000 :
		$signed(scaled) / $signed({17'h00000, ref_p_abs});
	reg [23:0] val_p;
	reg [23:0] val_s;

	always @* begin
		case (jmode_ff)
		`JMODE_DEV_COUNT: begin
			val_p = diff_p[23:0];
			val_s = diff_s[23:0];
		end
		`JMODE_DEV_PERCENT: begin
			val_p = pct_full[23:0];
			val_s = diff_s[23:0];
		end
		default: begin
			val_p = meas_primary;
			val_s = meas_secondary;
		end
		endcase
	end

	// primary judged against slot 0 in compare mode, bins use slots 1..13
	wire [1:0] jp_cmp = judgment_mode_menu(val_p, lim_hi_ff[0], lim_lo_ff[0],
		meas_error | p_overflow, p_underflow);
	wire [1:0] js = judgment_mode_menu(val_s, sec_hi_ff, sec_lo_ff,
		meas_error | s_overflow, s_underflow);
	wire [`NUM_BINS:1] bin_pass;

	genvar gi;
	generate
		for (gi = 1; gi <= `NUM_BINS; gi = gi + 1) begin : g_bin
			wire [1:0] jb = judgment_mode_menu(val_p, lim_hi_ff[gi], lim_lo_ff[gi],
				meas_error | p_overflow, p_underflow);
			assign bin_pass[gi] = (jb == `JUDGMENT_MODE_MENU_PASS);
		end
	endgenerate

	reg [3:0] bin_hit;
	integer k;
	always @* begin
		bin_hit = 4'h0;
		// lowest numbered passing bin wins when ranges overlap
		for (k = `NUM_BINS; k >= 1; k = k - 1) begin
			if (bin_pass[k])
				bin_hit = k[3:0];
		end
	end

	wire sec_ok = (js == `JUDGMENT_MODE_MENU_PASS) || (js == `JUDGMENT_MODE_MENU_NONE);
	wire [3:0] nxt_cat = sec_ok ? bin_hit : 4'h0;
	wire cmp_and = (jp_cmp == `JUDGMENT_MODE_MENU_PASS) && (js == `JUDGMENT_MODE_MENU_PASS);
	wire cmp_judged = (jp_cmp != `JUDGMENT_MODE_MENU_NONE) || (js != `JUDGMENT_MODE_MENU_NONE);

	// apb read mux
	reg [31:0] rd_data;
	reg rd_err;
	always @* begin
		rd_data = 32'h00000000;
		rd_err = 1'b0;
		if (is_lim_hi)
			rd_data = {7'h00, lim_hi_ff[hi_idx]};
		else if (is_lim_lo)
			rd_data = {7'h00, lim_lo_ff[lo_idx]};
		else begin
			case (paddr)
			`OFS_CTRL: rd_data = {28'h0000000, tone_ff, mode_ff};
			`OFS_KEY: rd_data = {31'h00000000, trigger_source_select};
			`OFS_JSEL: rd_data = {26'h0000000, jmode_ff, 2'h0, jsel_ff};
			`OFS_COND: rd_data = {16'h0000, cond_ff};
			`OFS_MENU: rd_data = {23'h000000, menu_dash_ff, 4'h0, menu_ff};
			`OFS_STATUS: rd_data = {16'h0000, sort_category, 3'h0, fail_flag,
				and_pass, p_below_flag, p_pass, p_above_flag,
				1'b0, s_below_flag, s_pass, s_above_flag};
			`OFS_DISP_P: rd_data = {{8{disp_p_ff[23]}}, disp_p_ff};
			`OFS_DISP_S: rd_data = {{8{disp_s_ff[23]}}, disp_s_ff};
			`OFS_REF_P: rd_data = {8'h00, ref_p_ff};
			`OFS_REF_S: rd_data = {8'h00, ref_s_ff};
			`OFS_SEC_HI: rd_data = {7'h00, sec_hi_ff};
			`OFS_SEC_LO: rd_data = {7'h00, sec_lo_ff};
			default: rd_err = 1'b1;
			endcase
		end
	end

	// answer in the first access cycle; prdata and pslverr are latched at setup
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			prdata <= 32'h00000000;
			pslverr <= 1'b0;
		end else begin
			pready <= setup;
			if (setup) begin
				prdata <= pwrite ? 32'h00000000 : rd_data;
				pslverr <= rd_err;
			end
		end
	end

	wire plain = (mode_ff == `MODE_PLAIN);
	wire key_wr = wr_en && (paddr == `OFS_KEY);
	// source as it stands after this key write, so a shot in the same word sees it
	wire src_next = trigger_source_select ^ (key_wr && pwdata[`KEY_TRIG]);
	wire [15:0] menu_mask = `MENU_CMP_ALLOWED >> pwdata[3:0];

	// configuration registers
	integer s;
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mode_ff <= `MODE_PLAIN;
			tone_ff <= 2'h0;
			jmode_ff <= `JMODE_COUNT;
			jsel_ff <= `JMODE_COUNT;
			cond_ff <= `RST_COND;
			menu_ff <= 4'h0;
			menu_dash_ff <= 1'b0;
			ref_p_ff <= `RST_REF_P;
			ref_s_ff <= `RST_REF_S;
			sec_hi_ff <= `RST_LIMIT;
			sec_lo_ff <= `RST_LIMIT;
			strap_done_ff <= 1'b0;
			trigger_source_select <= 1'b0;
			for (s = 0; s < `NUM_SLOTS; s = s + 1) begin
				lim_hi_ff[s] <= `RST_LIMIT;
				lim_lo_ff[s] <= `RST_LIMIT;
			end
		end else begin
			// saved mode is caught once, just after reset release
			strap_done_ff <= 1'b1;
			if (!strap_done_ff && saved_sort_mode)
				mode_ff <= `MODE_SORT;
			if (key_wr && pwdata[`KEY_TRIG])
				trigger_source_select <= ~trigger_source_select;
			if (key_wr && pwdata[`KEY_CONFIRM] && plain) begin
				jmode_ff <= jsel_ff;
				menu_ff <= `MENU_TONE_ITEM;
				menu_dash_ff <= 1'b0;
			end
			if (wr_en) begin
				if (is_lim_hi)
					lim_hi_ff[hi_idx] <= pwdata[24:0];
				if (is_lim_lo)
					lim_lo_ff[lo_idx] <= pwdata[24:0];
				case (paddr)
				`OFS_CTRL: begin
					if (strap_done_ff)
						mode_ff <= pwdata[`CTRL_MODE_LSB +: 2];
					tone_ff <= pwdata[`CTRL_TONE_LSB +: 2];
				end
				`OFS_JSEL: begin
					if (plain)
						jsel_ff <= pwdata[1:0];
				end
				`OFS_COND: begin
					if (plain)
						cond_ff <= pwdata[15:0];
				end
				`OFS_MENU: begin
					menu_ff <= pwdata[3:0];
					menu_dash_ff <= (mode_ff == `MODE_COMPARE) && !menu_mask[0];
				end
				`OFS_REF_P: ref_p_ff <= pwdata[23:0];
				`OFS_REF_S: ref_s_ff <= pwdata[23:0];
				`OFS_SEC_HI: sec_hi_ff <= pwdata[24:0];
				`OFS_SEC_LO: sec_lo_ff <= pwdata[24:0];
				default: ;
				endcase
			end
		end
	end

	// judgment outputs, updated once per measurement
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			p_below_flag <= 1'b0;
			p_pass <= 1'b0;
			p_above_flag <= 1'b0;
			s_below_flag <= 1'b0;
			s_pass <= 1'b0;
			s_above_flag <= 1'b0;
			and_pass <= 1'b0;
			fail_flag <= 1'b0;
			rear_parallel_port <= 14'h0000;
			sort_category <= 4'h0;
			result_valid <= 1'b0;
			tone_pass <= 1'b0;
			tone_fail <= 1'b0;
			disp_p_ff <= 24'h000000;
			disp_s_ff <= 24'h000000;
		end else begin
			result_valid <= 1'b0;
			tone_pass <= 1'b0;
			tone_fail <= 1'b0;
			if (meas_valid) begin
				result_valid <= 1'b1;
				disp_p_ff <= val_p;
				disp_s_ff <= val_s;
				s_below_flag <= (js == `JUDGMENT_MODE_MENU_BELOW);
				s_pass <= (js == `JUDGMENT_MODE_MENU_PASS);
				s_above_flag <= (js == `JUDGMENT_MODE_MENU_ABOVE);
				if (mode_ff == `MODE_SORT) begin
					p_below_flag <= 1'b0;
					p_pass <= 1'b0;
					p_above_flag <= 1'b0;
					and_pass <= 1'b0;
					sort_category <= nxt_cat;
					fail_flag <= (nxt_cat == 4'h0);
					rear_parallel_port <= 14'h0001 << nxt_cat;
					tone_pass <= tone_ff[`TONE_PASS_BIT] && (nxt_cat != 4'h0);
					tone_fail <= tone_ff[`TONE_FAIL_BIT] && (nxt_cat == 4'h0);
				end else if (mode_ff == `MODE_COMPARE) begin
					p_below_flag <= (jp_cmp == `JUDGMENT_MODE_MENU_BELOW);
					p_pass <= (jp_cmp == `JUDGMENT_MODE_MENU_PASS);
					p_above_flag <= (jp_cmp == `JUDGMENT_MODE_MENU_ABOVE);
					and_pass <= cmp_and;
					fail_flag <= cmp_judged && !cmp_and;
					sort_category <= 4'h0;
					rear_parallel_port <= 14'h0000;
					tone_pass <= tone_ff[`TONE_PASS_BIT] && cmp_and;
					tone_fail <= tone_ff[`TONE_FAIL_BIT] && cmp_judged && !cmp_and;
				end else begin
					p_below_flag <= 1'b0;
					p_pass <= 1'b0;
					p_above_flag <= 1'b0;
					s_below_flag <= 1'b0;
					s_pass <= 1'b0;
					s_above_flag <= 1'b0;
					and_pass <= 1'b0;
					fail_flag <= 1'b0;
					sort_category <= 4'h0;
					rear_parallel_port <= 14'h0000;
				end
			end
		end
	end

	// trigger, range and saved-mode outputs
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			meas_start <= 1'b0;
			auto_range <= 1'b0;
			saved_sort_mode_out <= 1'b0;
		end else begin
			// key write and source toggle in the same word: the toggle lands first
			meas_start <= key_wr && pwdata[`KEY_SHOT] && src_next;
			auto_range <= cond_ff[`COND_AUTO_RANGE] && (mode_ff != `MODE_SORT);
			saved_sort_mode_out <= (mode_ff == `MODE_SORT);
		end
	end

endmodule
`default_nettype wire

/* File: bench/judgment_mode_menu_chk_sva.sv */
// concurrent checks on the limit judgment_mode_menu ports
`timescale 1ns/10ps
`default_nettype none
module judgment_mode_menu_chk (
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire pready,
	input wire [7:0] paddr,
	input wire [31:0] pwdata,
	input wire meas_valid,
	input wire meas_error,
	input wire p_overflow,
	input wire p_below_flag,
	input wire p_pass,
	input wire p_above_flag,
	input wire s_pass,
	input wire and_pass,
	input wire [13:0] rear_parallel_port,
	input wire [3:0] sort_category,
	input wire result_valid,
	input wire tone_pass,
	input wire trigger_source_select,
	input wire meas_start,
	input wire saved_sort_mode_out,
	input wire auto_range
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	a_result_lat: assert property (meas_valid |=> result_valid)
		else $error("result pulse missing");
	a_range_above: assert property (meas_valid && (meas_error || p_overflow) |=>
		!p_pass && !p_below_flag) else $error("range fault not above");
	a_flag_onehot: assert property ($onehot0({p_below_flag, p_pass, p_above_flag}))
		else $error("primary flags not exclusive");
	a_and_both: assert property (and_pass |-> p_pass && s_pass)
		else $error("combined pass without both");
	a_flag_hold: assert property (!meas_valid |=>
		$stable({p_below_flag, p_pass, p_above_flag, and_pass})) else $error("flags moved");
	a_tone_res: assert property (tone_pass |-> result_valid)
		else $error("tone without result");
	a_trig_flip: assert property (psel && penable && pready && pwrite && paddr == 8'h04
		&& pwdata[0] |=> trigger_source_select != $past(trigger_source_select))
		else $error("trigger source not toggled");
	a_shot_once: assert property (meas_start |-> trigger_source_select ##1 !meas_start)
		else $error("bad single shot");
	a_sort_hold: assert property (saved_sort_mode_out |-> !auto_range)
		else $error("auto range in sort");
	a_bin_port: assert property (result_valid && saved_sort_mode_out |->
		rear_parallel_port == 14'h1 << sort_category) else $error("port not category");
endmodule
bind limit_judgment_mode_menu_and_sorter judgment_mode_menu_chk u_chk (.pclk, .presetn, .psel, .penable, .pwrite,
	.pready, .paddr, .pwdata, .meas_valid, .meas_error, .p_overflow, .p_below_flag, .p_pass,
	.p_above_flag, .s_pass, .and_pass, .rear_parallel_port, .sort_category, .result_valid,
	.tone_pass, .trigger_source_select, .meas_start, .saved_sort_mode_out, .auto_range);
`default_nettype wire

/* File: bench/handler_model.sv */
// handler latching each judgment from the rear port
`timescale 1ns/10ps
`default_nettype none
module handler_model (
	input wire logic pclk,
	input wire logic result_valid,
	input wire logic [13:0] rear_parallel_port,
	input wire logic and_pass,
	output var logic [13:0] got_port,
	output var logic got_pass,
	output var int seen
);
	initial seen = 0;
	// outputs are read only on the result pulse, as a real handler strobes them
	always @(posedge pclk) begin
		if (result_valid) begin
			got_port <= rear_parallel_port;
			got_pass <= and_pass;
			seen <= seen + 1;
		end
	end
endmodule
`default_nettype wire

/* File: bench/tb.sv */
// bench driving apb and measurements into the limit judgment_mode_menu
`timescale 1ns/10ps
`default_nettype none
module tb;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, meas_valid = 0;
	logic meas_error = 0, p_overflow = 0, p_underflow = 0, s_overflow = 0, s_underflow = 0;
	logic saved_sort_mode = 0, pready, pslverr, saved_sort_mode_out, p_below_flag, p_pass;
	logic p_above_flag, s_below_flag, s_pass, s_above_flag, and_pass, fail_flag;
	logic result_valid, tone_pass, tone_fail, trigger_source_select, meas_start, auto_range;
	logic got_pass;
	logic [7:0] paddr = 8'h0;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic [23:0] meas_primary = 24'h0, meas_secondary = 24'h0;
	logic [13:0] rear_parallel_port, got_port;
	logic [3:0] sort_category;
	int errors = 0, compares = 0, cyc = 0, seen;
	logic [23:0] pv [7] = '{24'h32, 24'hFFFF6A, 24'h96, 24'h32, 24'h32, 24'h32, 24'hFFFF6A};
	logic [4:0] fv [7] = '{5'h0, 5'h0, 5'h0, 5'h8, 5'h4, 5'h10, 5'h10};
	logic [2:0] ev [7] = '{3'h2, 3'h4, 3'h1, 3'h1, 3'h4, 3'h1, 3'h1};
	logic [23:0] bv [3] = '{24'h96, 24'hFA, 24'h1F4};
	logic [3:0] cv [3] = '{4'h2, 4'h3, 4'h0};
	limit_judgment_mode_menu_and_sorter DUT (.*);
	handler_model hm (.pclk, .result_valid, .rear_parallel_port, .and_pass, .got_port,
		.got_pass, .seen);
	initial forever #2 pclk = ~pclk;
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 4000) begin
			errors++;
			end_sim();
		end
	end
	task automatic end_sim;
		$display("errors=%0d compares=%0d", errors, compares);
		if (errors == 0 && compares > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		compares++;
		if (g !== e) begin
			errors++;
			$display("wrong value %s exp %h got %h", n, e, g);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic tick;
		@(posedge pclk);
		#1;
	endtask
	task automatic meas(input logic [23:0] p, input logic [23:0] s, input logic [4:0] f);
		@(posedge pclk);
		meas_valid <= 1'b1;
		meas_primary <= p;
		meas_secondary <= s;
		{meas_error, p_overflow, p_underflow, s_overflow, s_underflow} <= f;
		@(posedge pclk);
		meas_valid <= 1'b0;
		#1;
		chk("result", 1, result_valid);
	endtask
	initial begin
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		repeat (3) @(posedge pclk);
		apb(0, 8'h0C, 0);
		chk("cond", 32'h1, rd);
		apb(0, 8'h30, 0);
		chk("slverr", 1, pslverr);
		apb(1, 8'h00, 32'h1);
		apb(1, 8'h40, 32'h64);
		apb(1, 8'h80, 32'hFFFF9C);
		apb(1, 8'h0C, 0);
		apb(0, 8'h0C, 0);
		chk("cond", 32'h1, rd);
		// secondary limits are still off, so only the primary is judged
		foreach (pv[i]) begin
			meas(pv[i], 24'h0, fv[i]);
			chk("pflags", ev[i], {p_below_flag, p_pass, p_above_flag});
			chk("sflags", 0, {s_below_flag, s_pass, s_above_flag});
		end
		apb(1, 8'h28, 32'hA);
		apb(1, 8'h2C, 32'h0);
		// tones on for pass and fail, still compare mode
		apb(1, 8'h00, 32'hD);
		meas(24'h32, 24'h5, 0);
		chk("tone", 2'h2, {tone_pass, tone_fail});
		tick();
		chk("and", 1, hm.got_pass);
		meas(24'h32, 24'h14, 0);
		chk("tone", 2'h1, {tone_pass, tone_fail});
		chk("flags", 3'h5, {s_above_flag, and_pass, fail_flag});
		apb(1, 8'h10, 32'h9);
		apb(0, 8'h10, 0);
		chk("dash", 1, rd[8]);
		// meas_start stands one cycle only, so look just after the write edge
		apb(1, 8'h04, 32'h2);
		#1;
		chk("shot", 0, meas_start);
		apb(1, 8'h04, 32'h1);
		tick();
		chk("trig", 1, trigger_source_select);
		apb(1, 8'h04, 32'h2);
		#1;
		chk("shot", 1, meas_start);
		apb(1, 8'h00, 32'h2);
		apb(1, 8'h48, 32'hC8);
		apb(1, 8'h88, 32'h64);
		apb(1, 8'h4C, 32'h12C);
		apb(1, 8'h8C, 32'h0);
		foreach (bv[i]) begin
			meas(bv[i], 24'h5, 0);
			chk("cat", cv[i], sort_category);
			// the handler latches on the result pulse, one edge later
			tick();
			chk("port", 14'h1 << cv[i], got_port);
		end
		apb(0, 8'h18, 0);
		chk("disp", 32'h1F4, rd);
		chk("range", 0, auto_range);
		apb(1, 8'h08, 32'h1);
		apb(1, 8'h04, 32'h4);
		apb(0, 8'h08, 0);
		chk("jsel", 0, rd[5:4]);
		apb(1, 8'h00, 32'h0);
		apb(1, 8'h08, 32'h1);
		apb(1, 8'h04, 32'h4);
		apb(0, 8'h08, 0);
		chk("jsel", 1, rd[5:4]);
		apb(0, 8'h10, 0);
		chk("menu", 4'h5, rd[3:0]);
		apb(1, 8'h00, 32'h2);
		meas(24'h18736, 24'h5, 0);
		chk("cat", 4'h2, sort_category);
		apb(0, 8'h18, 0);
		chk("disp", 32'h96, rd);
		apb(1, 8'h00, 32'h0);
		apb(1, 8'h08, 32'h2);
		apb(1, 8'h04, 32'h4);
		apb(1, 8'h00, 32'h2);
		meas(24'h1ADB0, 24'h5, 0);
		apb(0, 8'h18, 0);
		chk("disp", 32'h3E8, rd);
		apb(0, 8'h1C, 0);
		chk("disp", 32'h5, rd);
		chk("seen", 14, seen);
		saved_sort_mode <= 1'b1;
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		repeat (2) tick();
		chk("sort", 1, saved_sort_mode_out);
		end_sim();
	end
endmodule
`default_nettype wire
